// ---- src/dssc_top.sv ----
// two-wire slave control for a 10-bit voltage converter
// assumes a bus master on scl/sda; scl is its own clock domain, clk is the core clock
//
// Operation
// - data register drives the converter code
// - only data and setup registers exist
// - standby bit one selects standby
// - standby freezes converter code updates
// - serial port keeps working in standby
// - answer only the fixed slave address
// - slave address is a build parameter
// - compare upper seven bits of byte
// - direction bit one reads, zero writes
// - pull data low on ninth clock
// - acknowledge data byte after storing it
`timescale 1ns/1ps
`default_nettype none
`include "dssc_defines.svh"
module dssc_top #(
  parameter logic [6:0] SLAVE_ADDR = `DSSC_ADDR_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic [9:0] dac_code,
  output logic standby
);
  import dssc_pkg::*;

  // ==========================================================
  // start and stop detection, scl domain
  // ==========================================================
  // start and stop are sda edges while scl is high; each edge moves its flag away
  // from a clear copy, and the next scl rise brings the copy level with it again
  logic start_flag_q;
  logic stop_flag_q;
  logic start_seen;
  logic stop_seen;
  logic start_clr_q;
  logic stop_clr_q;
  always_ff @(negedge sda_in or negedge reset_n)
  begin
    if (!reset_n)
      start_flag_q <= 1'b0;
    else if (scl)
      start_flag_q <= ~start_clr_q;
  end
  always_ff @(posedge sda_in or negedge reset_n)
  begin
    if (!reset_n)
      stop_flag_q <= 1'b0;
    else if (scl)
      stop_flag_q <= ~stop_clr_q;
  end
  assign start_seen = start_flag_q ^ start_clr_q;
  assign stop_seen = stop_flag_q ^ stop_clr_q;

  // ==========================================================
  // byte engine, scl domain (shifts on rise, drives on fall)
  // ==========================================================
  dssc_state_t state_q, state_d;
  dssc_phase_t phase_q, phase_d;
  logic [3:0] bit_q, bit_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] tx_q, tx_d;
  logic sel_setup_q, sel_setup_d;
  logic [9:0] data_q, data_d;
  logic [7:0] setup_q, setup_d;
  logic [7:0] hi_byte_q, hi_byte_d;
  logic drive_q, drive_d;
  logic upd_tog_q, upd_tog_d;
  logic [7:0] rx;

  assign rx = {shift_q[6:0], sda_in};

  always_comb
  begin
    state_d = state_q;
    phase_d = phase_q;
    bit_d = bit_q;
    shift_d = shift_q;
    sel_setup_d = sel_setup_q;
    data_d = data_q;
    setup_d = setup_q;
    hi_byte_d = hi_byte_q;
    upd_tog_d = upd_tog_q;
    if (start_seen)
    begin
      state_d = ST_ADDR;
      bit_d = 4'h1;
      shift_d = {7'h00, sda_in};
    end
    else if (stop_seen)
      state_d = ST_IDLE;
    else
    begin
      case (state_q)
        ST_ADDR, ST_WBYTE:
        begin
          shift_d = rx;
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7)
          begin
            bit_d = 4'h0;
            if (state_q == ST_ADDR)
            begin
              if (rx[7:1] == SLAVE_ADDR)
              begin
                state_d = ST_ADDR_ACK;
                phase_d = rx[0] ? phase_q : PH_CMD;
              end
              else
                state_d = ST_IGNORE;
            end
            else
            begin
              // store before the ack slot that follows
              state_d = ST_WACK;
              case (phase_q)
                PH_CMD:
                begin
                  if (rx == `DSSC_CMD_SETUP)
                    sel_setup_d = 1'b1;
                  else
                    sel_setup_d = 1'b0;
                  phase_d = PH_HI;
                end
                PH_HI:
                begin
                  if (sel_setup_q)
                    setup_d = rx;
                  else
                    hi_byte_d = rx;
                  phase_d = PH_LO;
                end
                default:
                begin
                  if (!sel_setup_q)
                  begin
                    data_d = {hi_byte_q, rx[7:6]};
                    upd_tog_d = ~upd_tog_q;
                  end
                end
              endcase
            end
          end
        end
        ST_ADDR_ACK:
          state_d = shift_q[0] ? ST_RBYTE : ST_WBYTE;
        ST_WACK:
          state_d = ST_WBYTE;
        ST_RBYTE:
        begin
          bit_d = bit_q + 4'h1;
          if (bit_q == 4'h7)
          begin
            bit_d = 4'h0;
            state_d = ST_RACK;
          end
        end
        ST_RACK:
          state_d = sda_in ? ST_IGNORE : ST_RBYTE;
        default:
          state_d = state_q;
      endcase
    end
  end

  // data byte to send: setup reads back, data sends high then low part
  always_comb
  begin
    tx_d = tx_q;
    if (state_q == ST_ADDR_ACK && shift_q[0])
      tx_d = sel_setup_q ? setup_q : data_q[9:2];
    else if (state_q == ST_RACK)
      tx_d = sel_setup_q ? setup_q : {data_q[1:0], 6'h00};
    else if (state_q == ST_RBYTE)
      tx_d = {tx_q[6:0], 1'b0};
  end

  always_ff @(posedge scl or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q <= ST_IDLE;
      phase_q <= PH_CMD;
      bit_q <= 4'h0;
      shift_q <= 8'h00;
      sel_setup_q <= 1'b0;
      data_q <= `DSSC_DATA_RESET;
      setup_q <= `DSSC_SETUP_RESET;
      hi_byte_q <= 8'h00;
      upd_tog_q <= 1'b0;
      tx_q <= 8'h00;
      start_clr_q <= 1'b0;
      stop_clr_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      bit_q <= bit_d;
      shift_q <= shift_d;
      sel_setup_q <= sel_setup_d;
      data_q <= data_d;
      setup_q <= setup_d;
      hi_byte_q <= hi_byte_d;
      upd_tog_q <= upd_tog_d;
      tx_q <= tx_d;
      start_clr_q <= start_flag_q;
      stop_clr_q <= stop_flag_q;
    end
  end

  // sda driver changes on scl falling edge only
  always_comb
  begin
    drive_d = 1'b0;
    case (state_q)
      ST_ADDR_ACK, ST_WACK:
        drive_d = 1'b1;
      ST_RBYTE:
        drive_d = ~tx_q[7];
      default:
        drive_d = 1'b0;
    endcase
  end
  always_ff @(negedge scl or negedge reset_n)
  begin
    if (!reset_n)
      drive_q <= 1'b0;
    else
      drive_q <= drive_d;
  end
  assign sda_out = 1'b0;
  assign sda_oe = drive_q;

  // ==========================================================
  // core domain: converter code and standby
  // ==========================================================
  logic [`DSSC_SYNC_STAGES-1:0] tog_sync_q;
  logic [`DSSC_SYNC_STAGES-1:0] sb_sync_q;
  logic tog_seen_q;
  logic [9:0] code_d, code_q;
  logic standby_q;
  always_comb
  begin
    code_d = code_q;
    // data is stable for many core cycles after the toggle, so a direct capture is safe
    if ((tog_sync_q[1] != tog_seen_q) && !sb_sync_q[1])
      code_d = data_q;
  end
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      tog_sync_q <= '0;
      sb_sync_q <= '0;
      tog_seen_q <= 1'b0;
      code_q <= `DSSC_DATA_RESET;
      standby_q <= 1'b0;
    end
    else
    begin
      tog_sync_q <= {tog_sync_q[0], upd_tog_q};
      sb_sync_q <= {sb_sync_q[0], setup_q[`DSSC_STANDBY_BIT]};
      tog_seen_q <= sb_sync_q[1] ? tog_seen_q : tog_sync_q[1];
      code_q <= code_d;
      standby_q <= sb_sync_q[1];
    end
  end
  assign dac_code = code_q;
  assign standby = standby_q;

  // ==========================================================
  // checks
  // ==========================================================
  chk_standby_follow: assert property (@(posedge clk) disable iff (!reset_n)
    sb_sync_q[1] |=> standby) else $error("standby not set");
  chk_code_frozen: assert property (@(posedge clk) disable iff (!reset_n)
    sb_sync_q[1] |=> $stable(dac_code)) else $error("code changed in standby");
  chk_code_load: assert property (@(posedge clk) disable iff (!reset_n)
    ((tog_sync_q[1] != tog_seen_q) && !sb_sync_q[1]) |=> dac_code == $past(data_q)) else $error("code not loaded");
  chk_addr_ack: assert property (@(posedge scl) disable iff (!reset_n)
    (state_q == ST_ADDR_ACK) |-> sda_oe) else $error("address not acknowledged");
  chk_ack_drive: assert property (@(posedge scl) disable iff (!reset_n)
    (state_q == ST_WACK) |-> sda_oe) else $error("no ack");
  chk_read_release: assert property (@(posedge scl) disable iff (!reset_n)
    (state_q == ST_RACK) |-> !sda_oe) else $error("data line held in master ack slot");
  chk_ignore_quiet: assert property (@(posedge scl) disable iff (!reset_n)
    (state_q == ST_IGNORE) |-> !sda_oe) else $error("drove while ignored");
  chk_start_addr: assert property (@(posedge scl) disable iff (!reset_n)
    start_seen |=> (state_q == ST_ADDR)) else $error("start did not restart address");
  cov_standby: cover property (@(posedge clk) disable iff (!reset_n) $rose(standby));
  cov_code: cover property (@(posedge clk) disable iff (!reset_n) $changed(dac_code));
  cov_read: cover property (@(posedge scl) disable iff (!reset_n) state_q == ST_RACK);
endmodule : dssc_top
`default_nettype wire

// ---- pkg/dssc_defines.svh ----
// constants for the serial slave converter control block
// assumes inclusion by bare name from the package and the design
`ifndef DSSC_DEFINES_SVH
`define DSSC_DEFINES_SVH
`define DSSC_ADDR_DEFAULT 7'h48
`define DSSC_CMD_DATA 8'h00
`define DSSC_CMD_SETUP 8'h01
`define DSSC_STANDBY_BIT 0
`define DSSC_DATA_RESET 10'h000
`define DSSC_SETUP_RESET 8'h00
`define DSSC_SYNC_STAGES 2
`endif

// ---- pkg/dssc_pkg.sv ----
// types for the serial slave converter control block
// assumes dssc_defines.svh is on the include path
`include "dssc_defines.svh"
package dssc_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_WBYTE, ST_WACK, ST_RBYTE, ST_RACK, ST_IGNORE} dssc_state_t;
  typedef enum logic [1:0] {PH_CMD, PH_HI, PH_LO} dssc_phase_t;
endpackage : dssc_pkg

// ---- verif/dssc_host.sv ----
// serial bus master model: drives scl and pulls sda low
// assumes the bench resolves sda with a pull-up; scl stands high outside frames
`timescale 1ns/1ps
`default_nettype none
module dssc_host (
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // one 80 ns bit: data set while scl low, sampled mid-high
  task automatic bit_io(input logic b, output logic s);
    sda_low = ~b;
    #20 scl = 1'b1;
    #20 s = sda;
    #20 scl = 1'b0;
    #20;
  endtask : bit_io
  task automatic start_c();
    sda_low = 1'b0;
    #20 scl = 1'b1;
    #20 sda_low = 1'b1;
    #20 scl = 1'b0;
    #20;
  endtask : start_c
  task automatic stop_c();
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #20 sda_low = 1'b0;
    #20;
  endtask : stop_c
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : wr
  // last byte of a read is not acknowledged
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask : rd
endmodule : dssc_host
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the converter serial slave
// assumes dssc_defines.svh on the include path and the host model beside it
`timescale 1ns/1ps
`default_nettype none
`include "dssc_defines.svh"
module tb_top;
  localparam logic [6:0] ADDR = `DSSC_ADDR_DEFAULT;
  logic clk = 1'b0;
  logic reset_n = 1'b1;
  logic scl, host_low, sda_out, sda_oe, standby, a;
  logic [9:0] dac_code;
  logic [7:0] r;
  wire logic sda;
  int error_cnt = 0;
  int checks = 0;
  // open drain with pull-up
  assign sda = ~(host_low | (sda_oe & ~sda_out));
  always #5 clk = ~clk;
  dssc_host u_dssc_host (.scl(scl), .sda_low(host_low), .sda(sda));
  dssc_top u_dssc_top (.clk(clk), .reset_n(reset_n), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .dac_code(dac_code), .standby(standby));
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : report_and_stop
  // write: address, command, n data bytes; a foreign address gets no ack
  task automatic wx(input logic [6:0] ad, input logic [7:0] cmd, input logic [9:0] v, input int n);
    u_dssc_host.start_c();
    u_dssc_host.wr({ad, 1'b0}, a);
    chk(a, ad != ADDR);
    if (ad == ADDR)
    begin
      u_dssc_host.wr(cmd, a);
      chk(a, 0);
      if (n > 0)
        u_dssc_host.wr(n == 1 ? v[7:0] : v[9:2], a);
      if (n > 0)
        chk(a, 0);
      if (n > 1)
        u_dssc_host.wr({v[1:0], 6'h00}, a);
      if (n > 1)
        chk(a, 0);
    end
    u_dssc_host.stop_c();
  endtask : wx
  task automatic wait_code(input logic [9:0] exp);
    int i;
    for (i = 0; i < 20 && dac_code !== exp; i++)
      @(posedge clk);
    chk(dac_code, exp);
    if (i == 20)
      report_and_stop();
  endtask : wait_code
  // read one byte after optional command phase; it is the last byte when n is 1
  task automatic rx(input logic cmd_ph, input logic [7:0] cmd, input int n);
    u_dssc_host.start_c();
    if (cmd_ph)
    begin
      u_dssc_host.wr({ADDR, 1'b0}, a);
      u_dssc_host.wr(cmd, a);
      u_dssc_host.start_c();
    end
    u_dssc_host.wr({ADDR, 1'b1}, a);
    chk(a, 0);
    u_dssc_host.rd(n == 1, r);
  endtask : rx
  task automatic t_code();
    wx(ADDR, `DSSC_CMD_DATA, 10'h2d5, 2);
    wait_code(10'h2d5);
    $display("test code done");
  endtask : t_code
  task automatic t_addr();
    wx(ADDR ^ 7'h01, `DSSC_CMD_DATA, 10'h0f0, 2);
    wx(ADDR ^ 7'h40, `DSSC_CMD_DATA, 10'h0f0, 2);
    repeat (20) @(posedge clk);
    chk(dac_code, 10'h2d5);
    $display("test address done");
  endtask : t_addr
  task automatic t_standby();
    wx(ADDR, `DSSC_CMD_SETUP, 10'h001, 1);
    repeat (20) @(posedge clk);
    chk(standby, 1);
    wx(ADDR, `DSSC_CMD_DATA, 10'h13e, 2);
    repeat (20) @(posedge clk);
    chk(dac_code, 10'h2d5);
    rx(1, `DSSC_CMD_DATA, 2);
    chk(r, 8'h4f);
    u_dssc_host.rd(1, r);
    u_dssc_host.stop_c();
    chk(r[7:6], 2'h2);
    rx(1, `DSSC_CMD_SETUP, 1);
    u_dssc_host.stop_c();
    chk(r, 8'h01);
    rx(0, 8'h00, 1);
    u_dssc_host.stop_c();
    chk(r, 8'h01);
    wx(ADDR, `DSSC_CMD_SETUP, 10'h000, 1);
    repeat (20) @(posedge clk);
    chk(standby, 0);
    wx(ADDR, `DSSC_CMD_DATA, 10'h13c, 2);
    wait_code(10'h13c);
    $display("test standby done");
  endtask : t_standby
  initial
  begin
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk(dac_code, `DSSC_DATA_RESET);
    t_code();
    t_addr();
    t_standby();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
